// ===== logic/asspc_cfg.svh
// timing, field and code constants for the converter select and power-down control
`ifndef ASSPC_CFG_SVH
`define ASSPC_CFG_SVH

`define ASSPC_CLK_NS     25
`define ASSPC_DEB_NS     100
`define ASSPC_CONV_NS    2750
`define ASSPC_BBM_NS     50
`define ASSPC_RESUME_US  1
`define ASSPC_TMR_W      12

`define ASSPC_PD_CMD     4'he
`define ASSPC_TST_LAST   4'hd
`define ASSPC_LEN8       2'h1
`define ASSPC_LEN16      2'h3
`define ASSPC_FIN8       5'h07
`define ASSPC_FIN12      5'h0b
`define ASSPC_FIN16      5'h0f
`define ASSPC_ADDR_EDGE  3'h3
`define ASSPC_LEN_EDGE   3'h5
`define ASSPC_RCNT_MAX   3'h7
`define ASSPC_SAMP_EDGE  5'h03
`define ASSPC_BIT_TOP    4'hf
`define ASSPC_PAD        4'h0

`endif

// ===== logic/asspc_pkg.sv
// types for the converter select and power-down control
`default_nettype none
package asspc_pkg;

	typedef enum logic [3:0] {
		ST_SWPD = 4'h1,
		ST_APD  = 4'h2,
		ST_SAMP = 4'h4,
		ST_CONV = 4'h8
	} asspc_state_t;

	typedef struct packed {
		logic         cs_s1;
		logic         cs_s2;
		logic         cs_deb;
		logic [11:0]  deb_cnt;
		logic [2:0]   lv_s1;
		logic [2:0]   lv_s2;
		logic [2:0]   lv_s3;
		asspc_state_t state;
		logic         lnk_rst;
		logic [11:0]  tmr;
		logic [3:0]   addr;
		logic         mux_en;
		logic         samp_en;
		logic [11:0]  res;
		logic         eoc;
		logic         int_b;
	} asspc_ref_t;

	typedef struct packed {
		logic [2:0] cmd;
		logic [2:0] rcnt;
		logic [3:0] addr;
		logic [1:0] len;
		logic       seen;
	} asspc_rise_t;

	typedef struct packed {
		logic [4:0] fcnt;
		logic       samp;
		logic       hold;
	} asspc_fall_t;

endpackage
`default_nettype wire

// ===== logic/asspc_top.sv
// select, serial interface, power-down and conversion sequencing of the converter
`include "asspc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module asspc_top #(
	parameter int DEB_CYC  = (`ASSPC_DEB_NS + `ASSPC_CLK_NS - 1) / `ASSPC_CLK_NS,
	parameter int CONV_CYC = (`ASSPC_CONV_NS + `ASSPC_CLK_NS - 1) / `ASSPC_CLK_NS,
	parameter int BBM_CYC  = (`ASSPC_BBM_NS + `ASSPC_CLK_NS - 1) / `ASSPC_CLK_NS
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic        cs_b,
	input  wire logic        io_clk,
	input  wire logic        serial_command_in,
	input  wire logic        ref_int_sel,
	input  wire logic        flag_int_mode,
	input  wire logic [11:0] conv_code,
	output logic             sdo,
	output logic             sdo_oe_b,
	output logic             flag_out,
	output logic [3:0]       mux_sel,
	output logic             mux_en,
	output logic             sample_en,
	output logic             core_pwr_en,
	output logic             ref_pwr_en,
	output logic             conv_busy
);
	import asspc_pkg::*;

	localparam logic [11:0] DEB_LAST  = 12'(DEB_CYC - 1);
	localparam logic [11:0] CONV_LAST = 12'(CONV_CYC - 1);
	localparam logic [11:0] BBM_LAST  = 12'(BBM_CYC - 1);

	localparam asspc_ref_t REF_RST = '{
		cs_s1:   1'b1,
		cs_s2:   1'b1,
		cs_deb:  1'b1,
		lnk_rst: 1'b1,
		state:   ST_SWPD,
		eoc:     1'b1,
		int_b:   1'b1,
		default: '0
	};

	// reset release through two flops
	logic [1:0]  rst_sync_r;
	logic        rst_n;

	asspc_ref_t  ref_r;
	asspc_ref_t  ref_nxt;
	asspc_rise_t rise_r;
	asspc_rise_t rise_nxt;
	asspc_fall_t fall_r;
	asspc_fall_t fall_nxt;

	logic        lnk_rst;
	logic        dsel_low;
	logic        seen_rise;
	logic        samp_rise;
	logic        hold_rise;
	logic [4:0]  fin_edge;
	logic [15:0] out_word;
	logic [3:0]  out_idx;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_r[1];

	// link side is held in reset by a flop of the internal domain; release is
	// safe because the host keeps the serial clock idle after select settles
	assign lnk_rst = ref_r.lnk_rst;

	assign seen_rise = ref_r.lv_s2[0] & ~ref_r.lv_s3[0];
	assign samp_rise = ref_r.lv_s2[1] & ~ref_r.lv_s3[1];
	assign hold_rise = ref_r.lv_s2[2] & ~ref_r.lv_s3[2];

	// ------ internal clock domain
	always_comb begin
		ref_nxt = ref_r;
		dsel_low = 1'b0;

		ref_nxt.cs_s1 = cs_b;
		ref_nxt.cs_s2 = ref_r.cs_s1;
		if (ref_r.cs_s2 != ref_r.cs_deb) begin
			if (ref_r.deb_cnt == DEB_LAST) begin
				ref_nxt.cs_deb  = ref_r.cs_s2;
				ref_nxt.deb_cnt = 12'h000;
				dsel_low        = ~ref_r.cs_s2;
			end else begin
				ref_nxt.deb_cnt = ref_r.deb_cnt + 12'h001;
			end
		end else begin
			ref_nxt.deb_cnt = 12'h000;
		end

		ref_nxt.lv_s1 = {fall_r.hold, fall_r.samp, rise_r.seen};
		ref_nxt.lv_s2 = ref_r.lv_s1;
		ref_nxt.lv_s3 = ref_r.lv_s2;

		// serial clock is locked out while deselected and while converting
		ref_nxt.lnk_rst = ref_nxt.cs_deb | (ref_r.state == ST_CONV);

		if (seen_rise) begin
			ref_nxt.int_b = 1'b1;
		end

		case (ref_r.state)
			ST_SWPD, ST_APD: begin
				ref_nxt.samp_en = 1'b0;
				ref_nxt.mux_en  = 1'b0;
				if (samp_rise) begin
					ref_nxt.addr = rise_r.addr;
					ref_nxt.tmr  = 12'h000;
					if (rise_r.addr == `ASSPC_PD_CMD) begin
						ref_nxt.state = ST_SWPD;
					end else begin
						// any valid address wakes the converter
						ref_nxt.state = ST_SAMP;
					end
				end
				if (hold_rise) begin
					// cycle ends without conversion; re-arm the interface
					ref_nxt.lnk_rst = 1'b1;
				end
			end
			ST_SAMP: begin
				// mux stays open for a gap before the new input closes
				if (ref_r.tmr == BBM_LAST) begin
					ref_nxt.mux_en  = (ref_r.addr <= `ASSPC_TST_LAST);
					ref_nxt.samp_en = 1'b1;
				end else begin
					ref_nxt.tmr = ref_r.tmr + 12'h001;
				end
				if (hold_rise) begin
					ref_nxt.samp_en = 1'b0;
					ref_nxt.mux_en  = 1'b0;
					ref_nxt.state   = ST_CONV;
					ref_nxt.tmr     = 12'h000;
					ref_nxt.eoc     = 1'b0;
					ref_nxt.lnk_rst = 1'b1;
				end
			end
			ST_CONV: begin
				ref_nxt.lnk_rst = 1'b1;
				if (ref_r.tmr == CONV_LAST) begin
					ref_nxt.res     = conv_code;
					ref_nxt.eoc     = 1'b1;
					ref_nxt.int_b   = 1'b0;
					ref_nxt.state   = ST_APD;
					ref_nxt.lnk_rst = ref_nxt.cs_deb;
				end else begin
					ref_nxt.tmr = ref_r.tmr + 12'h001;
				end
			end
			default: begin
				ref_nxt.state = ST_SWPD;
			end
		endcase

		// a fresh select abandons sampling, or a conversion before its last cycle, and keeps the old result
		if (dsel_low && (ref_r.state == ST_SAMP || ref_r.state == ST_CONV)) begin
			ref_nxt.state   = ST_APD;
			ref_nxt.eoc     = 1'b1;
			ref_nxt.samp_en = 1'b0;
			ref_nxt.mux_en  = 1'b0;
			ref_nxt.lnk_rst = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_r <= REF_RST;
		end else if (clk_en) begin
			ref_r <= ref_nxt;
		end
	end

	// ------ serial clock domain, rising edges take command bits
	always_comb begin
		rise_nxt = rise_r;
		rise_nxt.cmd  = {rise_r.cmd[1:0], serial_command_in};
		rise_nxt.seen = 1'b1;
		if (rise_r.rcnt != `ASSPC_RCNT_MAX) begin
			rise_nxt.rcnt = rise_r.rcnt + 3'h1;
		end
		if (rise_r.rcnt == `ASSPC_ADDR_EDGE) begin
			rise_nxt.addr = {rise_r.cmd, serial_command_in};
		end
		if (rise_r.rcnt == `ASSPC_LEN_EDGE) begin
			rise_nxt.len = {rise_r.cmd[0], serial_command_in};
		end
	end

	// interface logic is never gated by power-down, only by select, by conversion and at frame end
	always_ff @(posedge io_clk or posedge lnk_rst) begin
		if (lnk_rst) begin
			rise_r <= '0;
		end else begin
			rise_r <= rise_nxt;
		end
	end

	// ------ serial clock domain, falling edges count bits
	always_comb begin
		case (rise_r.len)
			`ASSPC_LEN8:  fin_edge = `ASSPC_FIN8;
			`ASSPC_LEN16: fin_edge = `ASSPC_FIN16;
			default:      fin_edge = `ASSPC_FIN12;
		endcase
	end

	always_comb begin
		fall_nxt = fall_r;
		if (!fall_r.hold) begin
			fall_nxt.fcnt = fall_r.fcnt + 5'h01;
			if (fall_r.fcnt == `ASSPC_SAMP_EDGE) begin
				fall_nxt.samp = 1'b1;
			end
			if (fall_r.fcnt == fin_edge) begin
				fall_nxt.hold = 1'b1;
			end
		end
	end

	always_ff @(negedge io_clk or posedge lnk_rst) begin
		if (lnk_rst) begin
			fall_r <= '0;
		end else begin
			fall_r <= fall_nxt;
		end
	end

	// ------ pins
	// the result word only changes while the link is held in reset, so the
	// bit mux sees stable data from both domains
	assign out_word = {ref_r.res, `ASSPC_PAD};
	assign out_idx  = `ASSPC_BIT_TOP - fall_r.fcnt[3:0];
	assign sdo      = ref_r.eoc & out_word[out_idx];
	// raw pin on purpose: the line must be freed with no synchroniser delay
	assign sdo_oe_b = cs_b;
	assign flag_out = flag_int_mode ? ref_r.int_b : ref_r.eoc;

	assign mux_sel     = ref_r.addr;
	assign mux_en      = ref_r.mux_en;
	assign sample_en   = ref_r.samp_en;
	assign conv_busy   = ~ref_r.eoc;
	// core sleeps after each conversion, also with select held low, and wakes
	// once the selected link has clocked again
	assign core_pwr_en = (ref_r.state == ST_SAMP) | (ref_r.state == ST_CONV)
		| ((ref_r.state == ST_APD) & ~ref_r.cs_deb & ref_r.lv_s2[0]);
	assign ref_pwr_en  = ref_int_sel & (ref_r.state != ST_SWPD);

endmodule
`default_nettype wire

// ===== tb/asspc_props.sv
// concurrent checks on select, conversion and power-down pins
`timescale 1ns/10ps
`default_nettype none
module asspc_props (
	input wire logic       ref_clk,
	input wire logic       rst_b,
	input wire logic       cs_b,
	input wire logic       flag_int_mode,
	input wire logic       ref_int_sel,
	input wire logic       sdo,
	input wire logic       sdo_oe_b,
	input wire logic       flag_out,
	input wire logic [3:0] mux_sel,
	input wire logic       mux_en,
	input wire logic       sample_en,
	input wire logic       ref_pwr_en,
	input wire logic       conv_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// a select fall then a settled low level
	sequence cs_settled;
		$fell(cs_b) ##1 !cs_b [*8];
	endsequence
	chk_oe_follows_cs: assert property (sdo_oe_b == cs_b)
		else $error("enable differs from select");
	chk_conv_sdo_low: assert property (conv_busy |-> !sdo)
		else $error("data high in conversion");
	chk_done_low: assert property (!flag_int_mode && conv_busy |-> !flag_out)
		else $error("done high in conversion");
	chk_ref_kept: assert property (conv_busy && ref_int_sel |-> ref_pwr_en)
		else $error("reference off in conversion");
	chk_conv_ends: assert property ($rose(conv_busy) |-> ##[1:200] !conv_busy)
		else $error("conversion too long");
	chk_sample_held: assert property (conv_busy |-> !sample_en)
		else $error("sampling in conversion");
	chk_mux_bbm: assert property (mux_en |-> $stable(mux_sel) && mux_sel <= 4'hd)
		else $error("mux switched while closed");
	chk_cs_resets: assert property (cs_settled |-> !conv_busy && !sample_en)
		else $error("select did not reset");
endmodule
bind asspc_top asspc_props u_asspc_props (
	.ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .flag_int_mode(flag_int_mode),
	.ref_int_sel(ref_int_sel), .sdo(sdo), .sdo_oe_b(sdo_oe_b), .flag_out(flag_out),
	.mux_sel(mux_sel), .mux_en(mux_en), .sample_en(sample_en), .ref_pwr_en(ref_pwr_en),
	.conv_busy(conv_busy));
`default_nettype wire

// ===== tb/asspc_host.sv
// serial host model: select, link clock and command line
`timescale 1ns/10ps
`default_nettype none
module asspc_host (
	output var logic  cs_b,
	output var logic  io_clk,
	output var logic  serial_command_in,
	input  wire logic sdo,
	input  wire logic sdo_oe_b
);
	initial begin
		cs_b = 1'b1; // first frame needs a select fall
		io_clk = 1'b0;
		serial_command_in = 1'b0;
	end
	task automatic reselect;
		cs_b = 1'b1;
		#150 cs_b = 1'b0;
	endtask
	// clock idles low between frames; a released line reads as the inverse bit
	task automatic xfer(input logic [7:0] cmd, input int n, input bit tog,
		output logic [15:0] rx);
		rx = 16'h0;
		if (tog)
			reselect();
		#300; // clock held low after debounce
		for (int i = 0; i < n; i++) begin // whole frame, also for power-down
			serial_command_in = (i < 8) ? cmd[7 - i] : 1'b0;
			#24 io_clk = 1'b1;
			rx = {rx[14:0], sdo_oe_b ? ~rx[0] : sdo};
			#24 io_clk = 1'b0;
		end
		serial_command_in = ~serial_command_in;
	endtask
endmodule
`default_nettype wire

// ===== tb/asspc_top_tb.sv
// self-checking bench for the select and power-down control
`timescale 1ns/10ps
`default_nettype none
module asspc_top_tb;
	logic        ref_clk, rst_b, flag_int_mode, cs_b, io_clk, serial_command_in, sdo;
	logic        sdo_oe_b, flag_out, mux_en, sample_en, core_pwr_en, ref_pwr_en, conv_busy;
	logic [11:0] conv_code;
	logic [3:0]  mux_sel;
	logic [15:0] rx;
	int          n_mismatch, check_count;

	asspc_top #(.DEB_CYC(2), .CONV_CYC(40)) u_asspc_top (
		.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .cs_b(cs_b), .io_clk(io_clk),
		.serial_command_in(serial_command_in), .ref_int_sel(1'b1),
		.flag_int_mode(flag_int_mode), .conv_code(conv_code), .sdo(sdo), .sdo_oe_b(sdo_oe_b),
		.flag_out(flag_out), .mux_sel(mux_sel), .mux_en(mux_en), .sample_en(sample_en),
		.core_pwr_en(core_pwr_en), .ref_pwr_en(ref_pwr_en), .conv_busy(conv_busy));
	asspc_host u_asspc_host (.cs_b(cs_b), .io_clk(io_clk),
		.serial_command_in(serial_command_in), .sdo(sdo), .sdo_oe_b(sdo_oe_b));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("mismatches %0d, checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wait_conv(input logic busy);
		repeat (6) @(negedge ref_clk);
		chk(16'(conv_busy), 16'(busy));
		for (int k = 0; conv_busy !== 1'b0; k++) begin
			if (k == 200) begin
				n_mismatch++;
				finish_test();
			end
			@(negedge ref_clk);
		end
	endtask
	// looks at the sampling switch late in the frame
	task automatic frame(input logic [7:0] cmd, input int n, input bit tog, input logic samp);
		fork
			u_asspc_host.xfer(cmd, n, tog, rx);
			begin
				#900;
				chk(16'(sample_en), 16'(samp));
				if (samp) begin
					chk(16'(mux_sel), 16'(cmd[7:4]));
					chk(16'(mux_en), 16'(cmd[7:4] <= 4'hd));
				end
			end
		join
	endtask
	task automatic set_code(input logic [11:0] c);
		@(negedge ref_clk);
		conv_code = c;
	endtask
	task automatic t_stream;
		chk(16'({core_pwr_en, ref_pwr_en, flag_out}), 16'h1);
		set_code(12'ha5c);
		frame(8'h30, 12, 1'b1, 1'b1);
		chk(rx, 16'h0);
		wait_conv(1'b1);
		repeat (2) @(negedge ref_clk);
		chk(16'({ref_pwr_en, core_pwr_en}), 16'h2);
		set_code(12'h3c1);
		frame(8'hdc, 16, 1'b1, 1'b1);
		chk(rx, 16'ha5c0);
		wait_conv(1'b1);
	endtask
	task automatic t_powerdown;
		frame(8'he4, 8, 1'b1, 1'b0);
		chk(rx, 16'h003c);
		wait_conv(1'b0);
		chk(16'({ref_pwr_en, core_pwr_en, flag_out}), 16'h1);
		@(negedge ref_clk);
		flag_int_mode = 1'b1;
		frame(8'h00, 12, 1'b1, 1'b1);
		chk(rx, 16'h03c1);
		wait_conv(1'b1);
	endtask
	task automatic t_continuous;
		repeat (40000) @(negedge ref_clk); // resume time after wake-up
		chk(16'(flag_out), 16'h0);
		set_code(12'h5a7);
		frame(8'h1c, 16, 1'b0, 1'b1); // first result after wake-up not judged
		chk(16'(flag_out), 16'h1);
		wait_conv(1'b1);
		set_code(12'h111);
		frame(8'h2c, 16, 1'b0, 1'b1);
		chk(rx, 16'h5a70);
	endtask
	task automatic t_abort;
		repeat (6) @(negedge ref_clk);
		chk(16'(conv_busy), 16'h1);
		u_asspc_host.reselect();
		repeat (10) @(negedge ref_clk);
		chk(16'({conv_busy, flag_out}), 16'h1);
		frame(8'h3c, 16, 1'b1, 1'b1);
		chk(rx, 16'h5a70);
		wait_conv(1'b1);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		rst_b = 1'b0;
		flag_int_mode = 1'b0;
		conv_code = 12'h0;
		n_mismatch = 0;
		check_count = 0;
		repeat (8) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge ref_clk);
		t_stream();
		t_powerdown();
		t_continuous();
		t_abort();
		finish_test();
	end
endmodule
`default_nettype wire
